//--- src/nv_config_program_lock.sv
// Nonvolatile configuration copy, lock request and lock status control
`timescale 1ns/100ps
module nv_config_program_lock
    import nv_prog_pkg::*;
#(
    parameter int CFG_BITS    = CFG_BITS_DEF,
    parameter int WORD_CYCLES = WORD_CYCLES_DEF
) (
    input  wire logic                mclk_in,
    input  wire logic                arst_n_in,
    input  wire logic                reg_wr_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [7:0]          reg_wdata_in,
    output logic      [7:0]          reg_rdata_out,
    input  wire logic [CFG_BITS-1:0] cfg_bits_in,
    output logic      [CFG_BITS-1:0] nv_store_out,
    output logic                     nv_write_out,
    output logic                     nv_locked_flag_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PROG = 2'b10
    } prog_state_t;

    localparam int CNT_W = (WORD_CYCLES < 2) ? 1 : $clog2(WORD_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_CYCLES - 1);

    prog_state_t         state_q, state_d;
    logic                trig_q, trig_d;
    logic                lockreq_q, lockreq_d;
    logic                locked_q, locked_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [CFG_BITS-1:0] shadow_q, shadow_d;
    logic [CFG_BITS-1:0] store_q, store_d;
    logic [7:0]          rdata_q, rdata_d;
    logic                wsel;

    assign wsel = reg_wr_in && (reg_addr_in == NV_CTRL_ADDR);

    always_comb begin
        state_d   = state_q;
        trig_d    = trig_q;
        lockreq_d = lockreq_q;
        locked_d  = locked_q;
        cnt_d     = cnt_q;
        shadow_d  = shadow_q;
        store_d   = store_q;
        // Lock request is ordinary read/write storage, still writable after it takes effect
        if (wsel) begin
            lockreq_d = reg_wdata_in[LOCK_REQ_BIT];
        end
        unique case (state_q)
            ST_IDLE: begin
                // Copy is refused once locked; bit never sets so polling ends
                if (wsel && reg_wdata_in[COPY_TRIG_BIT] && !locked_q) begin
                    trig_d   = 1'b1;
                    shadow_d = cfg_bits_in;
                    cnt_d    = '0;
                    state_d  = ST_PROG;
                end
            end
            ST_PROG: begin
                // Snapshot taken at trigger so mid-copy config writes do not tear the image
                if (cnt_q == CNT_LAST) begin
                    store_d = shadow_q;
                    trig_d  = 1'b0;
                    state_d = ST_IDLE;
                    if (lockreq_d) begin
                        locked_d = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
        endcase
        if (locked_q) begin
            locked_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = 8'h00 & ~NV_CTRL_RSVD_MSK;
        rdata_d[COPY_TRIG_BIT] = trig_q;
        rdata_d[LOCK_REQ_BIT]  = lockreq_q;
        rdata_d[LOCKED_BIT]    = locked_q;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q   <= ST_IDLE;
            trig_q    <= NV_CTRL_RESET[COPY_TRIG_BIT];
            lockreq_q <= NV_CTRL_RESET[LOCK_REQ_BIT];
            locked_q  <= NV_CTRL_RESET[LOCKED_BIT];
            cnt_q     <= '0;
            shadow_q  <= '0;
            store_q   <= '0;
            rdata_q   <= NV_CTRL_RESET;
        end else begin
            state_q   <= state_d;
            trig_q    <= trig_d;
            lockreq_q <= lockreq_d;
            locked_q  <= locked_d;
            cnt_q     <= cnt_d;
            shadow_q  <= shadow_d;
            store_q   <= store_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata_out      = rdata_q;
    assign nv_store_out       = store_q;
    assign nv_write_out       = (state_q == ST_PROG);
    assign nv_locked_flag_out = locked_q;
endmodule

//--- src/nv_prog_pkg.sv
// Constants for the nonvolatile program and lock control block
package nv_prog_pkg;
    localparam logic [7:0] NV_CTRL_ADDR     = 8'hFF;
    localparam logic [7:0] NV_CTRL_RESET    = 8'h00;
    localparam int         COPY_TRIG_BIT    = 7;
    localparam int         LOCK_REQ_BIT     = 6;
    localparam int         LOCKED_BIT       = 5;
    localparam logic [7:0] NV_CTRL_RSVD_MSK = 8'h1F;
    localparam int         CFG_BITS_DEF     = 8;
    localparam int         WORD_CYCLES_DEF  = 4;
endpackage

//--- test/nv_checker.sv
// Copy and lock checks
`timescale 1ns/100ps
module nv_checker (input wire logic mclk_in, arst_n_in, reg_wr_in, nv_write_out, nv_locked_flag_out,
    input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, cfg_bits_in, nv_store_out);
    default clocking @(posedge mclk_in); endclocking default disable iff (!arst_n_in);
    sequence s_busy; nv_write_out [*4] ##1 !nv_write_out; endsequence
    property p_copy; reg_wr_in && reg_addr_in == 8'hFF && reg_wdata_in[7] && !nv_write_out
        && !nv_locked_flag_out |=> s_busy; endproperty
    property p_clear; $fell(nv_write_out) |=> !reg_rdata_out[7]; endproperty
    property p_lock; $fell(nv_write_out) && reg_rdata_out[6] && !$past(reg_wr_in) |-> nv_locked_flag_out;
    endproperty
    property p_keep; nv_locked_flag_out |=> $stable(nv_store_out); endproperty
    property p_flag; reg_rdata_out[5] == $past(nv_locked_flag_out); endproperty
    property p_rsvd; reg_rdata_out[4:0] == 5'h00; endproperty
    a_copy: assert property (p_copy) else $error("copy");
    a_clear: assert property (p_clear) else $error("clear");
    a_lock: assert property (p_lock) else $error("lock");
    a_keep: assert property (p_keep) else $error("keep");
    a_flag: assert property (p_flag) else $error("flag");
    a_rsvd: assert property (p_rsvd) else $error("rsvd");
endmodule
bind nv_config_program_lock nv_checker chk (.*);

//--- test/host_model.sv
// Register host model
`timescale 1ns/100ps
module host_model (input wire logic mclk_in, input wire logic [7:0] reg_rdata_out,
    output logic reg_wr_in = 1'h0, output logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00);
    task automatic wr(logic [7:0] a, d);
        @(posedge mclk_in) #1 {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'h1, a, d};
        @(posedge mclk_in) #1 {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'h0, ~a, ~d};
        for (int i = 0; i < 12 && (i < 2 || reg_rdata_out[7] !== 1'h0); i++) @(posedge mclk_in);
        #1;
    endtask
endmodule

//--- test/testbench.sv
// Bench for copy and lock control
`timescale 1ns/100ps
module testbench;
    logic mclk_in = 1'h0, arst_n_in = 1'h0, reg_wr_in, nv_write_out, nv_locked_flag_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, cfg_bits_in = 8'h00, nv_store_out;
    int miscompares, tests_run, req, lck, img, seq[6] = '{16'h12FF, 16'hFF9F, 16'hFF20, 16'hFFC0, 16'hFF80, 16'hFF00};
    always #10 mclk_in = ~mclk_in;
    host_model host (.*);
    nv_config_program_lock dut (.*);
    task automatic check(logic [15:0] seen, exp);
        tests_run++;
        miscompares += int'(seen !== exp);
        if (seen !== exp) $display("unexpected regs: expected %h seen %h", exp, seen);
    endtask
    task automatic op(logic [7:0] a, d);
        cfg_bits_in = 8'($urandom);
        req = (a == 8'hFF) ? d[6] : req;
        img = (a == 8'hFF && d[7] && !lck) ? cfg_bits_in : img;
        lck |= (a == 8'hFF && d[7] && req);
        host.wr(a, d);
        check({reg_rdata_out, nv_store_out}, {2'(req), lck[0], 5'h00, img[7:0]});
    endtask
    task automatic give_verdict(int late);
        $display("tests_run %0d miscompares %0d", tests_run, miscompares + late);
        if (miscompares + late == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial #20000 give_verdict(1);
    initial begin
        void'($urandom(32'hF350));
        #401 arst_n_in = 1'h1;
        foreach (seq[i]) op(seq[i][15:8], seq[i][7:0]);
        give_verdict(0);
    end
endmodule
